// ---- rtl/scan_seq_pkg.sv ----
// Package: constants, modes and carriers of the queue scan sequencer
package scan_seq_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_Q1_CTRL = 12'h000;
	localparam logic [11:0] ADDR_Q2_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_TIMER_CFG = 12'h00C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ARM_BIT = 8;
	localparam int CTRL_EDGE_BIT = 9;
	localparam int STAT_Q1_COMPLETE = 0;
	localparam int STAT_Q1_PAUSE = 1;
	localparam int STAT_Q1_OVERRUN = 2;
	localparam int STAT_Q2_COMPLETE = 4;
	localparam int STAT_Q2_PAUSE = 5;
	localparam int STAT_Q2_OVERRUN = 6;
	localparam int STAT_Q1_STATE_LSB = 8;
	localparam int STAT_Q2_STATE_LSB = 10;
	localparam int STAT_ARM_LSB = 12;

	// ----------------------------------------------------------------
	// Values after reset and timer figures
	// ----------------------------------------------------------------
	localparam logic [3:0] TIMER_SEL_RST = 4'h0;
	localparam int TIMER_MIN_LOG2 = 7;
	localparam int TIMER_MAX_LOG2 = 17;
	localparam logic [5:0] END_OF_QUEUE_CODE = 6'h3F;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_DISABLED = 3'h0,
		MODE_SW_SINGLE = 3'h1,
		MODE_EXT_SINGLE = 3'h2,
		MODE_GATED_SINGLE = 3'h3,
		MODE_TIMER_SINGLE = 3'h4,
		MODE_SW_CONT = 3'h5,
		MODE_EXT_CONT = 3'h6,
		MODE_TIMER_CONT = 3'h7
	} op_mode_t;

	// Queue state, Gray along idle -> run -> paused
	typedef enum logic [1:0] {
		Q_IDLE = 2'h0,
		Q_RUN = 2'h1,
		Q_PAUSED = 2'h3
	} queue_state_t;

	typedef struct packed {
		logic req;
		logic pause;
		logic eoq_code;
	} word_done_t;
endpackage : scan_seq_pkg

// ---- rtl/adc_queue_scan_sequencer.sv ----
// Scan-mode sequencer for two conversion queues with APB control
`timescale 1ns/100ps
`default_nettype none
module adc_queue_scan_sequencer #(
	parameter int TIMER_BITS = 17
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trigger1,
	input wire logic ext_trigger2,
	input wire logic converter_clock_tick,
	input wire logic conv_done,
	input wire logic conv_pause_bit,
	input wire logic conv_eoq,
	output logic conv_start,
	output logic conv_abort,
	output logic conv_queue2,
	output logic conv_restart,
	output logic word_fetch
);
	initial begin
		if (TIMER_BITS < scan_seq_pkg::TIMER_MAX_LOG2 || TIMER_BITS > 24)
			$error("TIMER_BITS out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		scan_seq_pkg::op_mode_t mode1;
		scan_seq_pkg::op_mode_t mode2;
		logic arm1;
		logic arm2;
		logic edge1;
		logic edge2;
		logic [3:0] tsel;
		scan_seq_pkg::queue_state_t st1;
		scan_seq_pkg::queue_state_t st2;
		logic cf1;
		logic pf1;
		logic tor1;
		logic cf2;
		logic pf2;
		logic tor2;
		logic busy;
		logic active2;
		logic fetch_gap;
		logic restart;
		logic fresh1;
		logic fresh2;
		logic [TIMER_BITS-1:0] timer;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic trig1_prev;
		logic trig2_prev;
		logic [31:0] rdata;
		logic start;
		logic abort;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// ----------------------------------------------------------------
	// Combinational helpers
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic t1_uses;
	logic t2_uses;
	logic t_expire;
	logic edge1_seen;
	logic edge2_seen;
	logic trig1;
	logic trig2;
	logic gate;
	logic [TIMER_BITS-1:0] t_mask;
	logic [4:0] t_log2;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign gate = s_reg.sync1[1];
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = s_reg.rdata;
	assign conv_start = s_reg.start;
	assign conv_abort = s_reg.abort;
	assign conv_queue2 = s_reg.active2;
	assign conv_restart = s_reg.restart;
	assign word_fetch = s_reg.fetch_gap;

	function automatic logic uses_timer(input scan_seq_pkg::op_mode_t m, input logic arm);
		uses_timer = (m == scan_seq_pkg::MODE_TIMER_CONT) ||
			(m == scan_seq_pkg::MODE_TIMER_SINGLE && arm);
	endfunction

	function automatic logic mode_trigger(input scan_seq_pkg::op_mode_t m, input logic arm,
		input logic edge_in, input logic tick, input logic in_run);
		logic single;
		single = (m == scan_seq_pkg::MODE_SW_SINGLE) || (m == scan_seq_pkg::MODE_EXT_SINGLE)
			|| (m == scan_seq_pkg::MODE_TIMER_SINGLE);
		unique case (m)
			scan_seq_pkg::MODE_SW_SINGLE: mode_trigger = arm;
			scan_seq_pkg::MODE_SW_CONT: mode_trigger = ~in_run;
			scan_seq_pkg::MODE_EXT_SINGLE,
			scan_seq_pkg::MODE_EXT_CONT: mode_trigger = edge_in;
			scan_seq_pkg::MODE_TIMER_SINGLE,
			scan_seq_pkg::MODE_TIMER_CONT: mode_trigger = tick;
			default: mode_trigger = 1'b0;
		endcase
		if (single && !arm)
			mode_trigger = 1'b0;
	endfunction

	always_comb begin
		t_log2 = 5'(scan_seq_pkg::TIMER_MIN_LOG2) + {1'b0, s_reg.tsel};
		if (t_log2 > 5'(scan_seq_pkg::TIMER_MAX_LOG2))
			t_log2 = 5'(scan_seq_pkg::TIMER_MAX_LOG2);
		t_mask = TIMER_BITS'((1 << t_log2) - 1);
	end

	assign t1_uses = uses_timer(s_reg.mode1, s_reg.arm1);
	assign t2_uses = uses_timer(s_reg.mode2, s_reg.arm2);
	assign t_expire = converter_clock_tick && (t1_uses || t2_uses) &&
		((s_reg.timer & t_mask) == t_mask);
	assign edge1_seen = s_reg.edge1 ? (s_reg.sync1[1] & ~s_reg.trig1_prev)
		: (~s_reg.sync1[1] & s_reg.trig1_prev);
	assign edge2_seen = s_reg.edge2 ? (s_reg.sync2[1] & ~s_reg.trig2_prev)
		: (~s_reg.sync2[1] & s_reg.trig2_prev);
	assign trig1 = mode_trigger(s_reg.mode1, s_reg.arm1, edge1_seen, t_expire,
		s_reg.st1 == scan_seq_pkg::Q_RUN);
	assign trig2 = mode_trigger(s_reg.mode2, s_reg.arm2, edge2_seen, t_expire,
		s_reg.st2 == scan_seq_pkg::Q_RUN);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic done1;
		logic done2;
		logic go1;
		logic gated;
		logic [5:0] hw_set;
		hw_set = '0;
		s_next = s_reg;
		s_next.start = 1'b0;
		s_next.abort = 1'b0;
		s_next.restart = 1'b0;
		s_next.fetch_gap = 1'b0;
		s_next.sync1 = {s_reg.sync1[0], ext_trigger1};
		s_next.sync2 = {s_reg.sync2[0], ext_trigger2};
		s_next.trig1_prev = s_reg.sync1[1];
		s_next.trig2_prev = s_reg.sync2[1];
		done1 = conv_done && s_reg.busy && !s_reg.active2;
		done2 = conv_done && s_reg.busy && s_reg.active2;
		gated = s_reg.mode1 == scan_seq_pkg::MODE_GATED_SINGLE;
		// Flags start clear so that the logic below shows only this cycle's events
		s_next.cf1 = 1'b0;
		s_next.pf1 = 1'b0;
		s_next.tor1 = 1'b0;
		s_next.cf2 = 1'b0;
		s_next.pf2 = 1'b0;
		s_next.tor2 = 1'b0;

		// Timer: counts on converter-clock ticks, rolls at interval
		if (!(t1_uses || t2_uses))
			s_next.timer = '0;
		else if (converter_clock_tick)
			s_next.timer = t_expire ? '0 : s_reg.timer + 1'b1;

		// Queue 1 and queue 2 word completion
		if (done1) begin
			s_next.busy = 1'b0;
			if (conv_eoq) begin
				s_next.st1 = scan_seq_pkg::Q_IDLE;
				s_next.cf1 = 1'b1;
				s_next.fetch_gap = 1'b1;
				if (s_reg.mode1 != scan_seq_pkg::MODE_SW_CONT &&
					s_reg.mode1 != scan_seq_pkg::MODE_EXT_CONT &&
					s_reg.mode1 != scan_seq_pkg::MODE_TIMER_CONT)
					s_next.arm1 = 1'b0;
				if (!t2_uses || s_reg.st2 == scan_seq_pkg::Q_IDLE)
					s_next.timer = '0;
			end else if (gated && !gate) begin
				s_next.st1 = scan_seq_pkg::Q_IDLE;
				s_next.arm1 = 1'b0;
				s_next.pf1 = 1'b1;
			end else if (conv_pause_bit && !gated) begin
				s_next.st1 = scan_seq_pkg::Q_PAUSED;
				s_next.pf1 = 1'b1;
			end
		end
		if (done2) begin
			s_next.busy = 1'b0;
			if (conv_eoq) begin
				s_next.st2 = scan_seq_pkg::Q_IDLE;
				s_next.cf2 = 1'b1;
				s_next.fetch_gap = 1'b1;
				if (s_reg.mode2 != scan_seq_pkg::MODE_SW_CONT &&
					s_reg.mode2 != scan_seq_pkg::MODE_EXT_CONT &&
					s_reg.mode2 != scan_seq_pkg::MODE_TIMER_CONT)
					s_next.arm2 = 1'b0;
				if (!t1_uses || s_reg.st1 == scan_seq_pkg::Q_IDLE)
					s_next.timer = '0;
			end else if (conv_pause_bit) begin
				s_next.st2 = scan_seq_pkg::Q_PAUSED;
				s_next.pf2 = 1'b1;
			end
		end

		// Triggers: overrun while running, else start or resume
		go1 = 1'b0;
		if (gated) begin
			if (s_reg.arm1 && gate && s_reg.st1 == scan_seq_pkg::Q_IDLE && !done1) begin
				s_next.st1 = scan_seq_pkg::Q_RUN;
				s_next.fresh1 = 1'b1;
			end
		end else if (trig1) begin
			if (s_reg.st1 == scan_seq_pkg::Q_RUN) begin
				if (s_reg.mode1 != scan_seq_pkg::MODE_SW_CONT)
					s_next.tor1 = 1'b1;
			end else if (!done1) begin
				s_next.fresh1 = s_reg.st1 == scan_seq_pkg::Q_IDLE;
				s_next.st1 = scan_seq_pkg::Q_RUN;
				go1 = 1'b1;
			end
		end
		if (trig2) begin
			if (s_reg.st2 == scan_seq_pkg::Q_RUN)
				s_next.tor2 = s_reg.mode2 != scan_seq_pkg::MODE_SW_CONT;
			else if (!done2) begin
				s_next.fresh2 = s_reg.st2 == scan_seq_pkg::Q_IDLE;
				s_next.st2 = scan_seq_pkg::Q_RUN;
			end
		end

		// Dispatch: queue 1 first; it preempts running queue 2
		if (s_next.st1 == scan_seq_pkg::Q_RUN && s_reg.busy && s_reg.active2 && !done2) begin
			s_next.abort = 1'b1;
			s_next.busy = 1'b0;
			s_next.st2 = scan_seq_pkg::Q_PAUSED;
		end else if (!s_next.busy && !s_reg.fetch_gap && !s_next.fetch_gap) begin
			if (s_next.st1 == scan_seq_pkg::Q_RUN) begin
				s_next.busy = 1'b1;
				s_next.active2 = 1'b0;
				s_next.start = 1'b1;
				s_next.restart = s_next.fresh1;
				s_next.fresh1 = 1'b0;
			end else if (s_next.st2 == scan_seq_pkg::Q_RUN &&
				s_reg.mode1 != scan_seq_pkg::MODE_SW_CONT) begin
				s_next.busy = 1'b1;
				s_next.active2 = 1'b1;
				s_next.start = 1'b1;
				s_next.restart = s_next.fresh2;
				s_next.fresh2 = 1'b0;
			end
		end

		// Register writes; set by hardware wins over clear
		hw_set = {s_next.tor2, s_next.pf2, s_next.cf2, s_next.tor1, s_next.pf1, s_next.cf1};
		s_next.cf1 = s_reg.cf1 | hw_set[0];
		s_next.pf1 = s_reg.pf1 | hw_set[1];
		s_next.tor1 = s_reg.tor1 | hw_set[2];
		s_next.cf2 = s_reg.cf2 | hw_set[3];
		s_next.pf2 = s_reg.pf2 | hw_set[4];
		s_next.tor2 = s_reg.tor2 | hw_set[5];
		if (wr) begin
			unique case (paddr)
				scan_seq_pkg::ADDR_Q1_CTRL: begin
					if (pwdata[scan_seq_pkg::CTRL_MODE_LSB +: 3] != s_reg.mode1) begin
						s_next.mode1 = scan_seq_pkg::op_mode_t'(
							pwdata[scan_seq_pkg::CTRL_MODE_LSB +: 3]);
						s_next.st1 = scan_seq_pkg::Q_IDLE;
						s_next.abort = s_reg.busy && !s_reg.active2;
						s_next.busy = s_reg.busy && s_reg.active2;
						s_next.start = 1'b0;
						s_next.arm1 = pwdata[scan_seq_pkg::CTRL_ARM_BIT];
						if (uses_timer(s_next.mode1, s_next.arm1))
							s_next.timer = '0;
					end else if (pwdata[scan_seq_pkg::CTRL_ARM_BIT])
						s_next.arm1 = 1'b1;
					s_next.edge1 = pwdata[scan_seq_pkg::CTRL_EDGE_BIT];
				end
				scan_seq_pkg::ADDR_Q2_CTRL: begin
					if (pwdata[scan_seq_pkg::CTRL_MODE_LSB +: 3] != s_reg.mode2) begin
						s_next.mode2 = scan_seq_pkg::op_mode_t'(
							pwdata[scan_seq_pkg::CTRL_MODE_LSB +: 3]);
						if (s_next.mode2 == scan_seq_pkg::MODE_GATED_SINGLE)
							s_next.mode2 = scan_seq_pkg::MODE_DISABLED;
						s_next.st2 = scan_seq_pkg::Q_IDLE;
						s_next.abort = s_reg.busy && s_reg.active2;
						s_next.busy = s_reg.busy && !s_reg.active2;
						s_next.start = s_next.start && !s_reg.busy ? 1'b0 : s_next.start;
						s_next.arm2 = pwdata[scan_seq_pkg::CTRL_ARM_BIT];
					end else if (pwdata[scan_seq_pkg::CTRL_ARM_BIT])
						s_next.arm2 = 1'b1;
					s_next.edge2 = pwdata[scan_seq_pkg::CTRL_EDGE_BIT];
				end
				scan_seq_pkg::ADDR_STATUS: begin
					// Write one to clear; events this cycle keep the flag
					if (pwdata[scan_seq_pkg::STAT_Q1_COMPLETE] && !hw_set[0])
						s_next.cf1 = 1'b0;
					if (pwdata[scan_seq_pkg::STAT_Q1_PAUSE] && !hw_set[1])
						s_next.pf1 = 1'b0;
					if (pwdata[scan_seq_pkg::STAT_Q1_OVERRUN] && !hw_set[2])
						s_next.tor1 = 1'b0;
					if (pwdata[scan_seq_pkg::STAT_Q2_COMPLETE] && !hw_set[3])
						s_next.cf2 = 1'b0;
					if (pwdata[scan_seq_pkg::STAT_Q2_PAUSE] && !hw_set[4])
						s_next.pf2 = 1'b0;
					if (pwdata[scan_seq_pkg::STAT_Q2_OVERRUN] && !hw_set[5])
						s_next.tor2 = 1'b0;
				end
				scan_seq_pkg::ADDR_TIMER_CFG: s_next.tsel = pwdata[3:0];
				default: ;
			endcase
		end

		// Read data, arm bits of the control registers read zero; status shows arm1 and arm2
		s_next.rdata = '0;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				scan_seq_pkg::ADDR_Q1_CTRL: begin
					s_next.rdata[scan_seq_pkg::CTRL_MODE_LSB +: 3] = s_reg.mode1;
					s_next.rdata[scan_seq_pkg::CTRL_EDGE_BIT] = s_reg.edge1;
				end
				scan_seq_pkg::ADDR_Q2_CTRL: begin
					s_next.rdata[scan_seq_pkg::CTRL_MODE_LSB +: 3] = s_reg.mode2;
					s_next.rdata[scan_seq_pkg::CTRL_EDGE_BIT] = s_reg.edge2;
				end
				scan_seq_pkg::ADDR_STATUS: begin
					s_next.rdata[scan_seq_pkg::STAT_Q1_COMPLETE] = s_reg.cf1;
					s_next.rdata[scan_seq_pkg::STAT_Q1_PAUSE] = s_reg.pf1;
					s_next.rdata[scan_seq_pkg::STAT_Q1_OVERRUN] = s_reg.tor1;
					s_next.rdata[scan_seq_pkg::STAT_Q2_COMPLETE] = s_reg.cf2;
					s_next.rdata[scan_seq_pkg::STAT_Q2_PAUSE] = s_reg.pf2;
					s_next.rdata[scan_seq_pkg::STAT_Q2_OVERRUN] = s_reg.tor2;
					s_next.rdata[scan_seq_pkg::STAT_Q1_STATE_LSB +: 2] = s_reg.st1;
					s_next.rdata[scan_seq_pkg::STAT_Q2_STATE_LSB +: 2] = s_reg.st2;
					s_next.rdata[scan_seq_pkg::STAT_ARM_LSB +: 2] = {s_reg.arm2, s_reg.arm1};
				end
				scan_seq_pkg::ADDR_TIMER_CFG: s_next.rdata[3:0] = s_reg.tsel;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.tsel <= scan_seq_pkg::TIMER_SEL_RST;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // adc_queue_scan_sequencer
`default_nettype wire

// ---- bench/seq_props.sv ----
// Checker: port-level properties of the queue scan sequencer
`timescale 1ns/100ps
`default_nettype none
module seq_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire logic word_fetch
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic rd = psel && penable && !pwrite;
	wire logic q2c = paddr == scan_seq_pkg::ADDR_Q2_CTRL;
	wire logic ctl = q2c || paddr == scan_seq_pkg::ADDR_Q1_CTRL;
	// ------------------------------------------------
	// Assertions and covers
	// ------------------------------------------------
	apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
		else $error("access phase without a clean answer");
	arm_reads_zero_a: assert property (rd && ctl |-> !prdata[8])
		else $error("arm bit read back as one");
	q2_no_gate_a: assert property (rd && q2c |-> prdata[2:0] != 3'h3)
		else $error("queue 2 holds the gated mode");
	state_code_a: assert property (rd && paddr == scan_seq_pkg::ADDR_STATUS
		|-> prdata[9:8] != 2'h2 && prdata[11:10] != 2'h2)
		else $error("queue state code out of range");
	fetch_holds_start_a: assert property (word_fetch |-> !conv_start)
		else $error("start during the extra fetch cycle");
	fetch_pulse_a: assert property (word_fetch |=> !word_fetch)
		else $error("extra fetch longer than one cycle");
	abort_after_write_a: assert property (conv_abort |-> $past(psel && penable && pwrite))
		else $error("abort without a register write");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	cover property (conv_start);
	cover property (word_fetch);
	cover property (conv_abort);
endmodule // seq_props
bind adc_queue_scan_sequencer seq_props seq_props_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .conv_start, .conv_abort, .word_fetch);
`default_nettype wire

// ---- bench/conv_model.sv ----
// Partner model: converter answering start pulses with done and qualifiers
`timescale 1ns/100ps
`default_nettype none
module conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire logic conv_queue2,
	input wire logic conv_restart,
	input wire logic [3:0] lat,
	input wire logic [2:0] pause_idx,
	output logic conv_done,
	output logic conv_pause_bit,
	output logic conv_eoq
);
	// ------------------------------------------------
	// Four words per queue, last one holds the end code
	// ------------------------------------------------
	int cnt;
	int idx[2];
	logic qsel;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			idx <= '{0, 0};
			qsel <= 1'b0;
			conv_done <= 1'b0;
			conv_pause_bit <= 1'b0;
			conv_eoq <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			// Qualifiers are meaningless outside done, so they toggle
			conv_pause_bit <= ~conv_pause_bit;
			conv_eoq <= ~conv_eoq;
			if (conv_restart) begin
				idx[conv_queue2] <= 0;
			end
			if (conv_abort) begin
				cnt <= 0;
			end else if (conv_start) begin
				cnt <= int'(lat);
				qsel <= conv_queue2;
			end else if (cnt == 1) begin
				cnt <= 0;
				conv_done <= 1'b1;
				conv_pause_bit <= idx[qsel] == int'(pause_idx);
				conv_eoq <= idx[qsel] == 3;
				idx[qsel] <= idx[qsel] + 1;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // conv_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Testbench: self-checking run of the queue scan sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic trig1 = 1'b0;
	logic trig2 = 1'b0;
	logic tick = 1'b0;
	logic [3:0] lat = 4'h2;
	logic [2:0] pidx = 3'h7;
	logic [31:0] prdata, r, rnd;
	logic pready, pslverr, done, pbit, end_of_queue_code, start, abort, q2, restart, fetch;
	int seed = 32'h87FB7EEA;
	int miscompares = 0;
	int n_compared = 0;
	int n1 = 0, n2 = 0, nab = 0, tk = 0, cyc = 0, fixlat = 0;
	adc_queue_scan_sequencer adc_queue_scan_sequencer_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_trigger1(trig1),
		.ext_trigger2(trig2), .converter_clock_tick(tick), .conv_done(done),
		.conv_pause_bit(pbit), .conv_eoq(end_of_queue_code), .conv_start(start), .conv_abort(abort),
		.conv_queue2(q2), .conv_restart(restart), .word_fetch(fetch));
	conv_model conv_model_inst (.pclk, .presetn, .conv_start(start), .conv_abort(abort),
		.conv_queue2(q2), .conv_restart(restart), .lat, .pause_idx(pidx), .conv_done(done),
		.conv_pause_bit(pbit), .conv_eoq(end_of_queue_code));
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		rnd = $random(seed);
		tick <= rnd[0];
		lat <= (fixlat != 0) ? 4'(fixlat) : {2'h0, rnd[2:1]} + 4'h2;
		cyc++;
		if (tick) tk++;
		if (start && !q2) n1++;
		if (start && q2) n2++;
		if (abort) nab++;
		if (cyc == 40000) begin
			miscompares++;
			finish_test;
		end
	end
	// ------------------------------------------------
	// Bus, compare and wait helpers
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(r & m, e);
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		chk(scan_seq_pkg::ADDR_STATUS, m, e);
	endtask
	task automatic wq(input logic q, input logic [31:0] d);
		apb(1'b1, q ? scan_seq_pkg::ADDR_Q2_CTRL : scan_seq_pkg::ADDR_Q1_CTRL, d);
	endtask
	task automatic wait_n(input logic qs, input int n, input int settle);
		for (int i = 0; i < 600 && (qs ? n2 : n1) < n; i++) @(posedge pclk);
		repeat (settle) @(posedge pclk);
	endtask
	task automatic test_end(input int t);
		$display("test %0d ended", t);
	endtask
	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(scan_seq_pkg::ADDR_Q1_CTRL, 32'hFFFFFFFF, 32'h0);
		stat(32'hFFFFFFFF, 32'h0);
		chk(scan_seq_pkg::ADDR_TIMER_CFG, 32'hF, {28'h0, scan_seq_pkg::TIMER_SEL_RST});
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		chk(12'h010, 32'hFFFFFFFF, 32'h0);
		for (int m = 0; m < 8; m++) begin
			wq(1'b1, 32'(m) | 32'h100);
			chk(scan_seq_pkg::ADDR_Q2_CTRL, 32'h107, (m == 3) ? 32'h0 : 32'(m));
		end
		wq(1'b1, 32'h0);
		stat(32'h0C00, 32'h0);
		test_end(0);
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h77);
		pidx <= 3'h1;
		n1 = 0;
		wq(1'b0, 32'h103);
		trig1 <= 1'b1;
		wait_n(1'b0, 4, 30);
		check(32'(n1), 32'h4);
		stat(32'h1303, 32'h1);
		trig1 <= 1'b0;
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h77);
		test_end(1);
		fixlat = 9;
		n1 = 0;
		wq(1'b0, 32'h103);
		trig1 <= 1'b1;
		wait_n(1'b0, 1, 0);
		trig1 <= 1'b0;
		wait_n(1'b0, 0, 40);
		check(32'(n1), 32'h1);
		stat(32'h1303, 32'h2);
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h2);
		wq(1'b0, 32'h103);
		trig1 <= 1'b1;
		wait_n(1'b0, 5, 40);
		check(32'(n1), 32'h5);
		stat(32'h1303, 32'h1);
		trig1 <= 1'b0;
		fixlat = 0;
		wq(1'b0, 32'h0);
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h77);
		test_end(2);
		n1 = 0;
		wq(1'b0, 32'h206);
		trig1 <= 1'b1;
		wait_n(1'b0, 2, 30);
		check(32'(n1), 32'h2);
		stat(32'h303, 32'h302);
		trig1 <= 1'b0;
		wait_n(1'b0, 0, 30);
		check(32'(n1), 32'h2);
		trig1 <= 1'b1;
		wait_n(1'b0, 4, 30);
		check(32'(n1), 32'h4);
		stat(32'h307, 32'h3);
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h77);
		pidx <= 3'h7;
		fixlat = 12;
		trig1 <= 1'b0;
		wait_n(1'b0, 0, 5);
		trig1 <= 1'b1;
		wait_n(1'b0, 5, 0);
		trig1 <= 1'b0;
		wait_n(1'b0, 0, 5);
		trig1 <= 1'b1;
		wait_n(1'b0, 8, 80);
		check(32'(n1), 32'h8);
		stat(32'h307, 32'h5);
		n1 = 0;
		wq(1'b0, 32'h006);
		trig1 <= 1'b0;
		wait_n(1'b0, 4, 60);
		check(32'(n1), 32'h4);
		fixlat = 0;
		wq(1'b0, 32'h0);
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h77);
		test_end(3);
		apb(1'b1, scan_seq_pkg::ADDR_TIMER_CFG, 32'h0);
		n2 = 0;
		wq(1'b1, 32'h104);
		tk = 0;
		while (tk < 110) @(posedge pclk);
		check(32'(n2), 32'h0);
		wait_n(1'b1, 4, 30);
		check(32'(n2), 32'h4);
		stat(32'h2070, 32'h10);
		tk = 0;
		while (tk < 400) @(posedge pclk);
		check(32'(n2), 32'h4);
		wq(1'b1, 32'h0);
		apb(1'b1, scan_seq_pkg::ADDR_STATUS, 32'h77);
		test_end(4);
		n1 = 0;
		wq(1'b0, 32'h5);
		wq(1'b1, 32'h5);
		n2 = 0;
		wait_n(1'b0, 30, 0);
		check(32'(n2), 32'h0);
		stat(32'h44, 32'h0);
		nab = 0;
		wq(1'b0, 32'h0);
		wait_n(1'b1, 3, 0);
		check(32'(nab != 0), 32'h1);
		check(32'(n2 >= 3), 32'h1);
		wq(1'b1, 32'h0);
		test_end(5);
		finish_test;
	end
endmodule // testbench
`default_nettype wire
